//--- bench/gpcd_props.sv
// assertions on the ports of the pin clear and level block
`timescale 1ns/100ps
`default_nettype none
module gpcd_props #(parameter ADDR_W = 12) (
  input wire logic              clk,
  input wire logic              rst_b,
  input wire logic              s_axi_awready,
  input wire logic              s_axi_bvalid,
  input wire logic              s_axi_bready,
  input wire logic              s_axi_arvalid,
  input wire logic              s_axi_arready,
  input wire logic [ADDR_W-1:0] s_axi_araddr,
  input wire logic              s_axi_rvalid,
  input wire logic              s_axi_rready,
  input wire logic [31:0]       s_axi_rdata,
  input wire logic [1:0]        s_axi_rresp,
  input wire logic [103:0]      pin_direction_bit,
  input wire logic [103:0]      drive_load_en,
  input wire logic [103:0]      general_pin_out_q,
  input wire logic [103:0]      general_pin_oe_b_q
);
  wire       rq = s_axi_arvalid && s_axi_arready;
  wire       hi = |s_axi_araddr[ADDR_W-1:5];
  wire [4:0] ra = s_axi_araddr[4:0];
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);
  a_drive_no_rise: assert property ($past(rst_b) |-> (general_pin_out_q
    & ~$past(general_pin_out_q) & ~$past(drive_load_en)) == 104'h0) else $error("drive rose");
  a_oe_follows_dir: assert property ($past(rst_b) |->
    general_pin_oe_b_q == $past(pin_direction_bit)) else $error("enable off direction");
  a_read_latency: assert property (rq |=> s_axi_rvalid) else $error("no read answer");
  a_read_hold: assert property (s_axi_rvalid && !s_axi_rready |=>
    s_axi_rvalid && $stable(s_axi_rdata)) else $error("read data dropped");
  a_read_unmapped: assert property (rq && hi |=>
    s_axi_rresp == 2'h2 && s_axi_rdata == 32'h0) else $error("unmapped read");
  a_clear_readback: assert property (rq && !hi && ra == 5'h00 |=>
    s_axi_rdata == $past(general_pin_out_q[31:0])) else $error("clear word readback");
  a_clear6_zero: assert property (rq && !hi && ra == 5'h0C |=>
    s_axi_rdata[31:8] == 24'h0) else $error("clear bank6 reserved");
  a_level6_zero: assert property (rq && !hi && ra == 5'h1C |=>
    s_axi_rdata[31:11] == 21'h0) else $error("level bank6 reserved");
  a_write_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
    else $error("write answer dropped");
  a_busy_ready: assert property (s_axi_bvalid |-> !s_axi_awready) else $error("ready busy");
endmodule
bind gpcd_top gpcd_props #(.ADDR_W(ADDR_W)) gpcd_props_inst (.*);
`default_nettype wire

//--- bench/tb_top.sv
// self-checking bench for the pin clear and level block
`timescale 1ns/100ps
`default_nettype none
module tb_top;
  logic         clk = 0, rst_b = 0, awv = 0, wv = 0, bry = 0, arv = 0, rry = 0;
  logic         late = 0;
  logic [3:0]   ws = 4'hF;
  logic [11:0]  awa = 0, ara = 0;
  logic [31:0]  wd = 0, d;
  logic [1:0]   r;
  logic [103:0] dir = '1, len = 0, lval = 0;
  logic [106:0] pin = 0;
  wire          awr, wrd, bv, arr, rv;
  wire [1:0]    bresp, rresp;
  wire [31:0]   rdat;
  wire [103:0]  pout, poe;
  int           num_errors = 0, n_checks = 0;
  gpcd_top gpcd_top_inst (.clk(clk), .rst_b(rst_b), .s_axi_awvalid(awv),
    .s_axi_awready(awr), .s_axi_awaddr(awa), .s_axi_awprot(3'h0), .s_axi_wvalid(wv),
    .s_axi_wready(wrd), .s_axi_wdata(wd), .s_axi_wstrb(ws), .s_axi_bvalid(bv),
    .s_axi_bready(bry), .s_axi_bresp(bresp), .s_axi_arvalid(arv), .s_axi_arready(arr),
    .s_axi_araddr(ara), .s_axi_arprot(3'h0), .s_axi_rvalid(rv), .s_axi_rready(rry),
    .s_axi_rdata(rdat), .s_axi_rresp(rresp), .pin_direction_bit(dir),
    .drive_load_en(len), .drive_load_val(lval), .general_pin_in(pin),
    .general_pin_out_q(pout), .general_pin_oe_b_q(poe));
  initial forever #2.5 clk = ~clk;
  // ==========================================================
  // shared tasks
  // ==========================================================
  task chk(input logic [106:0] got, input logic [106:0] exp);
    n_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task wr(input logic [11:0] a, input logic [31:0] v);
    @(posedge clk);
    awv <= 1;
    wv <= 1;
    awa <= a;
    wd <= v;
    bry <= !late;
    @(posedge clk);
    while (!(awr && wrd)) @(posedge clk);
    awv <= 0;
    wv <= 0;
    @(posedge clk);
    while (!bv) @(posedge clk);
    // late master: response waits with bready low first
    if (late) begin
      @(posedge clk);
      bry <= 1;
      @(posedge clk);
    end
    r = bresp;
    bry <= 0;
  endtask
  task rd(input logic [11:0] a);
    @(posedge clk);
    arv <= 1;
    ara <= a;
    rry <= !late;
    @(posedge clk);
    while (!arr) @(posedge clk);
    arv <= 0;
    @(posedge clk);
    while (!rv) @(posedge clk);
    if (late) begin
      @(posedge clk);
      rry <= 1;
      @(posedge clk);
    end
    d = rdat;
    r = rresp;
    rry <= 0;
  endtask
  task rc(input logic [11:0] a, input logic [31:0] e);
    rd(a);
    chk(d, e);
  endtask
  task ld(input logic [103:0] v);
    @(posedge clk);
    len <= '1;
    lval <= v;
    @(posedge clk);
    len <= 0;
    // let the load edge settle before outputs are looked at
    @(posedge clk);
  endtask
  // ==========================================================
  // scenarios
  // ==========================================================
  task t_reset;
    for (int i = 0; i < 8; i++) rc(12'(4 * i), 32'h0);
    chk(poe, {104{1'b1}});
    $display("reset values done");
  endtask
  task t_clear;
    dir <= '0;
    ld('1);
    rc(12'h000, 32'hFFFF_FFFF);
    wr(12'h000, 32'h0001_8000);
    chk(r, 2'h0);
    chk(pout[31:0], 32'hFFFE_7FFF);
    rc(12'h000, 32'hFFFE_7FFF);
    rc(12'h010, 32'hFFFE_7FFF);
    ws <= 4'h1;
    wr(12'h000, 32'hFFFF_FFFF);
    ws <= 4'hF;
    chk(pout[31:0], 32'hFFFE_7F00);
    $display("clear done");
  endtask
  task t_gate;
    dir <= {40'h0, 32'hFFFF_FFFF, 32'h0};
    ld('1);
    chk(poe, {40'h0, 32'hFFFF_FFFF, 32'h0});
    wr(12'h004, 32'hFFFF_FFFF);
    chk(pout[63:32], 32'hFFFF_FFFF);
    wr(12'h008, 32'h0000_FFFF);
    chk(pout[95:64], 32'hFFFF_0000);
    rc(12'h00C, 32'h0000_00FF);
    wr(12'h00C, 32'hFFFF_FFFF);
    chk(pout[103:96], 8'h00);
    ld('1);
    chk(pout, {104{1'b1}});
    $display("direction gate done");
  endtask
  task t_level;
    dir <= '1;
    pin <= {3'b101, 8'h3C, 32'h1234_5678, 32'h9ABC_DEF0, 32'hA5A5_0FF0};
    repeat (4) @(posedge clk);
    rc(12'h010, 32'hA5A5_0FF0);
    late = 1;
    rc(12'h014, 32'h9ABC_DEF0);
    late = 0;
    rc(12'h018, 32'h1234_5678);
    rc(12'h01C, 32'h0000_053C);
    // a read right after a pin change must still see the old level
    pin[0] <= 1'b1;
    rc(12'h010, 32'hA5A5_0FF0);
    rc(12'h010, 32'hA5A5_0FF1);
    $display("level done");
  endtask
  task t_bad;
    dir <= '0;
    rc(12'h020, 32'h0);
    chk(r, 2'h2);
    late = 1;
    wr(12'h020, 32'hFFFF_FFFF);
    late = 0;
    chk(r, 2'h2);
    wr(12'h010, 32'hFFFF_FFFF);
    chk(r, 2'h0);
    chk(pout, {104{1'b1}});
    $display("unmapped done");
  endtask
  task give_verdict;
    $display("checks %0d errors %0d", n_checks, num_errors);
    if (num_errors == 0 && n_checks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  initial begin
    repeat (20000) @(posedge clk);
    num_errors++;
    give_verdict();
  end
  initial begin
    repeat (16) @(posedge clk);
    rst_b <= 1;
    t_reset();
    t_clear();
    t_gate();
    t_level();
    t_bad();
    give_verdict();
  end
endmodule
`default_nettype wire

//--- verilog/gpcd_defs.vh
// constants for the pin clear-data and level-read block
`ifndef GPCD_DEFS_VH
`define GPCD_DEFS_VH

// ==========================================================================
// pin counts
// ==========================================================================
`define GPCD_DRV_PINS       104
`define GPCD_LVL_PINS       107
`define GPCD_WORD_PINS      32
`define GPCD_BANK6_BASE     96
`define GPCD_BANK6_DRV_W    8
`define GPCD_BANK6_LVL_W    11

// ==========================================================================
// register byte offsets
// ==========================================================================
`define GPCD_OFS_CLEAR_01   5'h00
`define GPCD_OFS_CLEAR_23   5'h04
`define GPCD_OFS_CLEAR_45   5'h08
`define GPCD_OFS_CLEAR_6    5'h0C
`define GPCD_OFS_LEVEL_01   5'h10
`define GPCD_OFS_LEVEL_23   5'h14
`define GPCD_OFS_LEVEL_45   5'h18
`define GPCD_OFS_LEVEL_6    5'h1C
`define GPCD_DEC_W          5

// ==========================================================================
// field values
// ==========================================================================
`define GPCD_DIR_OUT        1'b0
`define GPCD_DRV_RESET      1'b0
`define GPCD_DATA_W         32
`define GPCD_ZERO32         32'h0000_0000
`define GPCD_RESP_OKAY      2'h0
`define GPCD_RESP_SLVERR    2'h2

`endif

//--- verilog/gpcd_sync.v
// two-stage synchroniser for a vector of asynchronous pin levels
`timescale 1ns/100ps
`default_nettype none

module gpcd_sync #(
  parameter WIDTH = 107
) (
  input  wire             clk,
  input  wire             rst_b,
  input  wire [WIDTH-1:0] async_in,
  output reg  [WIDTH-1:0] sync_q
);

  reg [WIDTH-1:0] meta_q;

  // ========================================================================
  // first stage feeds only the second
  // ========================================================================
  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      meta_q <= {WIDTH{1'b0}};
      sync_q <= {WIDTH{1'b0}};
    end else begin
      meta_q <= async_in;
      sync_q <= meta_q;
    end
  end

endmodule

`default_nettype wire

//--- verilog/gpcd_top.v
// pin clear-data and pin level registers behind an AXI4-Lite slave
//
// Behaviour
// - a 1 written to a clear-data bit drives that pin's output drive state to 0, a 0 leaves it.
// - a clear-data write only touches pins whose direction bit selects output.
// - reading a clear-data bit returns the current output drive state of its pin.
// - in a paired clear-data word bits 31-16 act on the odd bank and bits 15-0 on the even bank.
// - the bank 6 clear-data word has only bits 7-0 for pins 96-103, the rest read zero.
// - for an input pin the level word returns the pin level synchronised to the clock.
// - for an output pin the level word returns the value being driven on it.
// - a level bit reads 0 for a low pin and 1 for a high pin.
// - in a paired level word bits 31-16 report the odd bank and bits 15-0 the even bank.
// - the bank 6 level word reports pins 96-106 in bits 10-0, bits 31-11 read zero.
// - a direction bit of 0 selects output and 1 selects input, and gates clear writes.
`timescale 1ns/100ps
`include "gpcd_defs.vh"
`default_nettype none

module gpcd_top #(
  parameter ADDR_W = 12
) (
  input  wire                         clk,
  input  wire                         rst_b,
  // axi4-lite write address
  input  wire                         s_axi_awvalid,
  output reg                          s_axi_awready,
  input  wire [ADDR_W-1:0]            s_axi_awaddr,
  input  wire [2:0]                   s_axi_awprot,
  // axi4-lite write data
  input  wire                         s_axi_wvalid,
  output reg                          s_axi_wready,
  input  wire [31:0]                  s_axi_wdata,
  input  wire [3:0]                   s_axi_wstrb,
  // axi4-lite write response
  output reg                          s_axi_bvalid,
  input  wire                         s_axi_bready,
  output reg  [1:0]                   s_axi_bresp,
  // axi4-lite read address
  input  wire                         s_axi_arvalid,
  output reg                          s_axi_arready,
  input  wire [ADDR_W-1:0]            s_axi_araddr,
  input  wire [2:0]                   s_axi_arprot,
  // axi4-lite read data
  output reg                          s_axi_rvalid,
  input  wire                         s_axi_rready,
  output reg  [31:0]                  s_axi_rdata,
  output reg  [1:0]                   s_axi_rresp,
  // per-pin direction bits from the direction register
  input  wire [`GPCD_DRV_PINS-1:0]    pin_direction_bit,
  // loads of the shared drive state from the output-data and set-data paths
  input  wire [`GPCD_DRV_PINS-1:0]    drive_load_en,
  input  wire [`GPCD_DRV_PINS-1:0]    drive_load_val,
  // pins
  input  wire [`GPCD_LVL_PINS-1:0]    general_pin_in,
  output reg  [`GPCD_DRV_PINS-1:0]    general_pin_out_q,
  output reg  [`GPCD_DRV_PINS-1:0]    general_pin_oe_b_q
);

  // ========================================================================
  // declarations
  // ========================================================================
  reg  [`GPCD_DEC_W-1:0]     wr_addr_q;
  reg                        wr_addr_full_q;
  reg  [31:0]                wr_data_q;
  reg  [3:0]                 wr_strb_q;
  reg                        wr_data_full_q;
  wire                       wr_fire;
  wire                       wr_hit;
  wire [`GPCD_DEC_W-1:0]     rd_addr;
  wire                       wr_upper_zero;
  wire                       rd_upper_zero;
  reg  [31:0]                rd_word;
  reg                        rd_hit;
  wire [31:0]                wr_bits;
  reg  [`GPCD_DRV_PINS-1:0]  clr_mask;
  reg  [`GPCD_DRV_PINS-1:0]  drive_q;
  wire [`GPCD_DRV_PINS-1:0]  drive_d;
  wire [`GPCD_LVL_PINS-1:0]  pin_sync;
  wire [`GPCD_LVL_PINS-1:0]  level;

  // ========================================================================
  // input synchroniser
  // ========================================================================
  gpcd_sync #(
    .WIDTH    (`GPCD_LVL_PINS)
  ) u_sync (
    .clk      (clk),
    .rst_b    (rst_b),
    .async_in (general_pin_in),
    .sync_q   (pin_sync)
  );

  // ========================================================================
  // write channel capture
  // ========================================================================
  assign wr_fire = wr_addr_full_q & wr_data_full_q & ~s_axi_bvalid;

  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      s_axi_awready  <= 1'b1;
      s_axi_wready   <= 1'b1;
      wr_addr_full_q <= 1'b0;
      wr_data_full_q <= 1'b0;
      wr_addr_q      <= {`GPCD_DEC_W{1'b0}};
      wr_data_q      <= `GPCD_ZERO32;
      wr_strb_q      <= 4'h0;
      s_axi_bvalid   <= 1'b0;
      s_axi_bresp    <= `GPCD_RESP_OKAY;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        s_axi_awready  <= 1'b0;
        wr_addr_full_q <= 1'b1;
        wr_addr_q      <= wr_upper_zero ? s_axi_awaddr[`GPCD_DEC_W-1:0]
                                        : {`GPCD_DEC_W{1'b1}};
      end
      if (s_axi_wvalid && s_axi_wready) begin
        s_axi_wready   <= 1'b0;
        wr_data_full_q <= 1'b1;
        wr_data_q      <= s_axi_wdata;
        wr_strb_q      <= s_axi_wstrb;
      end
      if (wr_fire) begin
        wr_addr_full_q <= 1'b0;
        wr_data_full_q <= 1'b0;
        s_axi_bvalid   <= 1'b1;
        s_axi_bresp    <= wr_hit ? `GPCD_RESP_OKAY : `GPCD_RESP_SLVERR;
      end
      if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid  <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready  <= 1'b1;
      end
    end
  end

  assign wr_upper_zero = (s_axi_awaddr[ADDR_W-1:`GPCD_DEC_W] == {(ADDR_W-`GPCD_DEC_W){1'b0}})
                         && (s_axi_awaddr[1:0] == 2'h0);
  assign rd_upper_zero = (s_axi_araddr[ADDR_W-1:`GPCD_DEC_W] == {(ADDR_W-`GPCD_DEC_W){1'b0}})
                         && (s_axi_araddr[1:0] == 2'h0);

  // level words accept writes without effect
  assign wr_hit = (wr_addr_q == `GPCD_OFS_CLEAR_01) || (wr_addr_q == `GPCD_OFS_CLEAR_23) ||
                  (wr_addr_q == `GPCD_OFS_CLEAR_45) || (wr_addr_q == `GPCD_OFS_CLEAR_6)  ||
                  (wr_addr_q == `GPCD_OFS_LEVEL_01) || (wr_addr_q == `GPCD_OFS_LEVEL_23) ||
                  (wr_addr_q == `GPCD_OFS_LEVEL_45) || (wr_addr_q == `GPCD_OFS_LEVEL_6);

  // ========================================================================
  // clear-data decode
  // ========================================================================
  // only bytes with their strobe set carry clear requests
  assign wr_bits = wr_data_q & {{8{wr_strb_q[3]}}, {8{wr_strb_q[2]}},
                                {8{wr_strb_q[1]}}, {8{wr_strb_q[0]}}};

  always @* begin
    clr_mask = {`GPCD_DRV_PINS{1'b0}};
    if (wr_fire) begin
      case (wr_addr_q)
        `GPCD_OFS_CLEAR_01: clr_mask[31:0]  = wr_bits;
        `GPCD_OFS_CLEAR_23: clr_mask[63:32] = wr_bits;
        `GPCD_OFS_CLEAR_45: clr_mask[95:64] = wr_bits;
        `GPCD_OFS_CLEAR_6:  clr_mask[103:96] = wr_bits[7:0];
        default:            clr_mask = {`GPCD_DRV_PINS{1'b0}};
      endcase
    end
  end

  // ========================================================================
  // shared output drive state, one slice per pin
  // ========================================================================
  genvar gi;
  generate
    for (gi = 0; gi < `GPCD_DRV_PINS; gi = gi + 1) begin : g_drv
      wire loaded;
      assign loaded = drive_load_en[gi] ? drive_load_val[gi] : drive_q[gi];
      // clear applies after any same-cycle load, only to output pins
      assign drive_d[gi] = (clr_mask[gi] && (pin_direction_bit[gi] == `GPCD_DIR_OUT))
                           ? 1'b0 : loaded;
      // output pins show their drive value, input pins their synced level
      assign level[gi] = (pin_direction_bit[gi] == `GPCD_DIR_OUT)
                         ? drive_q[gi] : pin_sync[gi];
    end
    for (gi = `GPCD_DRV_PINS; gi < `GPCD_LVL_PINS; gi = gi + 1) begin : g_inonly
      assign level[gi] = pin_sync[gi];
    end
  endgenerate

  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      drive_q            <= {`GPCD_DRV_PINS{`GPCD_DRV_RESET}};
      general_pin_out_q  <= {`GPCD_DRV_PINS{`GPCD_DRV_RESET}};
      general_pin_oe_b_q <= {`GPCD_DRV_PINS{1'b1}};
    end else begin
      drive_q            <= drive_d;
      general_pin_out_q  <= drive_d;
      // enable is low while the pin is driven
      general_pin_oe_b_q <= pin_direction_bit;
    end
  end

  // ========================================================================
  // read channel
  // ========================================================================
  assign rd_addr = rd_upper_zero ? s_axi_araddr[`GPCD_DEC_W-1:0] : {`GPCD_DEC_W{1'b1}};

  always @* begin
    rd_hit  = 1'b1;
    rd_word = `GPCD_ZERO32;
    case (rd_addr)
      `GPCD_OFS_CLEAR_01: rd_word = drive_q[31:0];
      `GPCD_OFS_CLEAR_23: rd_word = drive_q[63:32];
      `GPCD_OFS_CLEAR_45: rd_word = drive_q[95:64];
      `GPCD_OFS_CLEAR_6:  rd_word = {24'h00_0000, drive_q[103:96]};
      `GPCD_OFS_LEVEL_01: rd_word = level[31:0];
      `GPCD_OFS_LEVEL_23: rd_word = level[63:32];
      `GPCD_OFS_LEVEL_45: rd_word = level[95:64];
      `GPCD_OFS_LEVEL_6:  rd_word = {21'h00_0000, level[106:96]};
      default: begin
        rd_hit  = 1'b0;
        rd_word = `GPCD_ZERO32;
      end
    endcase
  end

  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= `GPCD_ZERO32;
      s_axi_rresp   <= `GPCD_RESP_OKAY;
    end else begin
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_arready <= 1'b0;
        s_axi_rvalid  <= 1'b1;
        s_axi_rdata   <= rd_word;
        s_axi_rresp   <= rd_hit ? `GPCD_RESP_OKAY : `GPCD_RESP_SLVERR;
      end
      if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid  <= 1'b0;
        s_axi_arready <= 1'b1;
      end
    end
  end

endmodule

`default_nettype wire
